/* hw/bel_clk_div.sv */
// divider giving the processor clock as a one-cycle enable
// assumes sys_clk_in is the 50 mhz oscillator
module bel_clk_div #(
  parameter int unsigned DIV = bel_pkg::MPU_DIV
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  bel_ctl_if.div ctl
);
  import bel_pkg::*;
  logic [3:0] cnt_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 4'h0;
      ctl.mpu_tick <= 1'b0;
    end else if (cnt_q == 4'(DIV - 1)) begin
      cnt_q <= 4'h0;
      ctl.mpu_tick <= 1'b1; // [RL16]
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ctl.mpu_tick <= 1'b0;
    end
  end
endmodule

/* hw/bel_timeout.sv */
// local bus time-out counter, counts processor clocks of one access
// assumes cyc_run stays high for the whole access
module bel_timeout #(
  parameter int unsigned LIMIT = bel_pkg::TIMEOUT_MPU_CLKS
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  bel_ctl_if.tmo ctl
);
  import bel_pkg::*;
  logic [TIMEOUT_W-1:0] cnt_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      ctl.expire <= 1'b0;
    end else if (!ctl.cyc_run) begin
      cnt_q <= '0;
      ctl.expire <= 1'b0;
    end else if (ctl.mpu_tick && !ctl.expire) begin
      if (cnt_q == TIMEOUT_W'(LIMIT - 1)) begin
        ctl.expire <= 1'b1; // [RL6]
      end
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

/* hw/bel_top.sv */
// bus error sources, backplane requester, arbiter and deadlock breaker
// assumes all inputs synchronous to sys_clk_in; backplane lines active low

// Function
// [RL1] owned bus: read 5, write 6 plus ack
// [RL2] system controller: read 8, write 9 plus delays
// [RL3] plain requester: read 8, write 9 plus delays
// [RL4] arbiter grants three periods after bus free
// [RL5] pass incoming grant after 2.5 periods
// [RL6] time-out aborts access after 524000 periods
// [RL7] two flags encode last bus error cause
// [RL8] backplane error line raises processor bus error
// [RL9] deadlock in plain cycle signals retry
// [RL10] processor aborts, backplane side takes local bus
// [RL11] deadlock in indivisible cycle: error, no halt
// [RL12] interlock fitted: hold mastership whole instruction
// [RL13] interlock removed: no early mastership
// [RL14] interlocked locations use only indivisible instructions
// [RL15] test-and-set is one read, one write
// [RL16] timing derived from 50 mhz oscillator
// [RL17] deadlock: processor needs backplane, slave needs local
// [RL18] flags hold until next bus error
module bel_top #(
  parameter int unsigned TIMEOUT_CLKS = bel_pkg::TIMEOUT_MPU_CLKS
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sys_ctrl_in,
  input wire logic interlock_fit_in,
  input wire logic cpu_cyc_in,
  input wire logic cpu_vme_in,
  input wire logic cpu_write_in,
  input wire logic indivisible_cycle_marker_n_in,
  input wire logic slave_req_in,
  input wire logic vme_bbsy_n_in,
  input wire logic vme_br3_n_in,
  input wire logic vme_bg_in_n_in,
  input wire logic vme_dtack_n_in,
  input wire logic vme_berr_n_in,
  output logic cpu_berr_n_out,
  output logic cpu_halt_n_out,
  output logic cpu_ack_out,
  output logic slave_grant_out,
  output logic timeout_source_flag_out,
  output logic backplane_error_flag_out,
  output logic vme_br_n_out,
  output logic vme_bbsy_n_out,
  output logic vme_bbsy_oe_out,
  output logic vme_bg_out_n_out,
  output logic vme_ds_n_out
);
  import bel_pkg::*;

  // ==========================================================
  // submodules
  bel_ctl_if ctl ();

  bel_clk_div #(.DIV(MPU_DIV)) u_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ctl(ctl.div)
  );

  bel_timeout #(.LIMIT(TIMEOUT_CLKS)) u_tmo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ctl(ctl.tmo)
  );

  assign ctl.cyc_run = cpu_cyc_in && cpu_berr_n_out;

  // ==========================================================
  // master cycle sequencer
  typedef enum logic [2:0] {
    M_IDLE, M_ARB, M_SETUP, M_STROBE, M_TAIL, M_DONE
  } bel_mst_t;

  bel_mst_t mst_q;
  logic [CNT_W-1:0] cnt_q;
  logic owned_q;
  logic locked;
  logic marker_on;
  logic deadlock;
  logic bp_err_hit;
  logic err_busy;
  logic grant_ok;
  logic want_bus;

  // backplane access that may start: no bus error pending
  function automatic logic start_ok(input logic cyc, input logic bp, input logic busy);
    start_ok = cyc && bp && !busy;
  endfunction

  assign marker_on = !indivisible_cycle_marker_n_in;
  // interlock keeps mastership through an indivisible instruction
  assign locked = interlock_fit_in && marker_on; // [RL12] [RL13]
  assign err_busy = !cpu_berr_n_out;
  assign deadlock = cpu_cyc_in && cpu_vme_in && slave_req_in
    && !err_busy && mst_q != M_DONE; // [RL17]
  assign bp_err_hit = mst_q == M_STROBE && !vme_berr_n_in; // [RL8]
  // system controller takes a free bus; others wait for the chain grant
  assign grant_ok = sys_ctrl_in ? (vme_bbsy_n_in && vme_br3_n_in == 1'b0)
                                : !vme_bg_in_n_in; // [RL2] [RL3]
  assign want_bus = start_ok(cpu_cyc_in, cpu_vme_in, err_busy) || locked;

  function automatic logic [CNT_W-1:0] tail_len(input logic wr);
    tail_len = wr ? CNT_W'(CYC_WRITE_TAIL) : CNT_W'(CYC_READ_TAIL);
  endfunction

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mst_q <= M_IDLE;
      cnt_q <= '0;
    end else if (bp_err_hit || deadlock || ctl.expire) begin
      // any bus error source abandons the cycle at once
      mst_q <= M_IDLE;
      cnt_q <= '0;
    end else if (ctl.mpu_tick) begin
      unique case (mst_q)
        M_IDLE: begin
          if (start_ok(cpu_cyc_in, cpu_vme_in, err_busy)) begin
            if (owned_q) begin
              mst_q <= M_SETUP;
              cnt_q <= CNT_W'(CYC_SETUP_TICKS - 1); // [RL1]
            end else begin
              mst_q <= M_ARB;
              cnt_q <= '0;
            end
          end
        end
        M_ARB: begin
          if (owned_q) begin
            mst_q <= M_SETUP;
            cnt_q <= CNT_W'(CYC_SETUP_TICKS + CYC_ARB_EXTRA - 1); // [RL2] [RL3]
          end
        end
        M_SETUP: begin
          if (cnt_q == '0) begin
            mst_q <= M_STROBE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_STROBE: begin
          if (!vme_dtack_n_in) begin
            mst_q <= M_TAIL;
            cnt_q <= tail_len(cpu_write_in) - 1'b1; // [RL1]
          end
        end
        M_TAIL: begin
          if (cnt_q == '0) begin
            mst_q <= M_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        M_DONE: begin
          if (!cpu_cyc_in) begin
            mst_q <= M_IDLE;
          end
        end
        default: begin
          mst_q <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vme_ds_n_out <= 1'b1;
      cpu_ack_out <= 1'b0;
    end else begin
      vme_ds_n_out <= !(mst_q == M_STROBE && !bp_err_hit && !deadlock);
      cpu_ack_out <= mst_q == M_DONE && cpu_cyc_in;
    end
  end

  // ==========================================================
  // requester: bus request and busy hold
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      owned_q <= 1'b0;
      vme_br_n_out <= 1'b1;
      vme_bbsy_n_out <= 1'b1;
      vme_bbsy_oe_out <= 1'b0;
    end else if (ctl.mpu_tick) begin
      if (!owned_q) begin
        vme_br_n_out <= !want_bus;
        if (want_bus && grant_ok) begin
          owned_q <= 1'b1;
          vme_br_n_out <= 1'b1;
          vme_bbsy_n_out <= 1'b0;
          vme_bbsy_oe_out <= 1'b1;
        end
      end else if (!want_bus && !locked && mst_q == M_IDLE) begin
        // release only once the indivisible sequence has ended
        owned_q <= 1'b0; // [RL12]
        vme_bbsy_n_out <= 1'b1;
        vme_bbsy_oe_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // arbiter and grant daisy chain
  logic [CNT_W-1:0] arb_cnt_q;
  logic [CNT_W-1:0] daisy_cnt_q;
  logic arb_cond;
  logic daisy_cond;

  assign arb_cond = sys_ctrl_in && !want_bus && !owned_q
    && vme_bbsy_n_in && !vme_br3_n_in;
  assign daisy_cond = !sys_ctrl_in && !want_bus && !owned_q && !vme_bg_in_n_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arb_cnt_q <= '0;
      daisy_cnt_q <= '0;
      vme_bg_out_n_out <= 1'b1;
    end else begin
      if (!arb_cond) begin
        arb_cnt_q <= '0;
      end else if (ctl.mpu_tick && arb_cnt_q != CNT_W'(ARB_GRANT_TICKS)) begin
        arb_cnt_q <= arb_cnt_q + 1'b1;
      end
      if (!daisy_cond) begin
        daisy_cnt_q <= '0;
      end else if (daisy_cnt_q != CNT_W'(DAISY_SYS_CLKS)) begin
        daisy_cnt_q <= daisy_cnt_q + 1'b1;
      end
      if (sys_ctrl_in) begin
        vme_bg_out_n_out <= !(arb_cond &&
          arb_cnt_q == CNT_W'(ARB_GRANT_TICKS - 1) && ctl.mpu_tick ||
          arb_cond && arb_cnt_q == CNT_W'(ARB_GRANT_TICKS)); // [RL4]
      end else begin
        vme_bg_out_n_out <= !(daisy_cond &&
          daisy_cnt_q >= CNT_W'(DAISY_SYS_CLKS - 1)); // [RL5]
      end
    end
  end

  // ==========================================================
  // processor bus error, halt and local bus hand-over
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_berr_n_out <= 1'b1;
      cpu_halt_n_out <= 1'b1;
    end else if (err_busy) begin
      if (!cpu_cyc_in) begin
        cpu_berr_n_out <= 1'b1;
        cpu_halt_n_out <= 1'b1;
      end
    end else if (deadlock) begin
      cpu_berr_n_out <= 1'b0; // [RL9] [RL11]
      cpu_halt_n_out <= marker_on; // [RL11]
    end else if (bp_err_hit || ctl.expire) begin
      cpu_berr_n_out <= 1'b0; // [RL6] [RL8]
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      slave_grant_out <= 1'b0;
    end else begin
      // processor gives up the local bus by ending its cycle
      slave_grant_out <= slave_req_in && (!cpu_cyc_in || slave_grant_out); // [RL10]
    end
  end

  // ==========================================================
  // error source flags
  bel_src_t src_d;

  // priority: deadlock, then backplane error, then time-out
  always_comb begin
    src_d = bel_src_t'({timeout_source_flag_out, backplane_error_flag_out});
    if (deadlock && marker_on) begin
      src_d = SRC_DEADLOCK; // [RL7]
    end else if (!deadlock && bp_err_hit) begin
      src_d = SRC_BACKPLANE; // [RL7]
    end else if (!deadlock && ctl.expire) begin
      src_d = SRC_TIMEOUT; // [RL7]
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timeout_source_flag_out <= 1'b0;
      backplane_error_flag_out <= 1'b0;
    end else if (!err_busy) begin
      // held until the next bus error other than a retry overwrites them
      {timeout_source_flag_out, backplane_error_flag_out} <= src_d; // [RL18]
    end
  end
endmodule

/* inc/bel_ctl_if.sv */
// carries the processor clock enable and time-out handshake between modules
// assumes one clock domain; all members are driven synchronously
interface bel_ctl_if;
  logic mpu_tick;
  logic cyc_run;
  logic expire;
  modport div (output mpu_tick);
  modport tmo (input mpu_tick, input cyc_run, output expire);
  modport top (input mpu_tick, input expire, output cyc_run);
endinterface

/* inc/bel_pkg.sv */
// constants shared by the bus error source and backplane lock logic
// assumes one 50 mhz system clock; the processor clock is half of it
package bel_pkg;
  // ==========================================================
  // clocking
  localparam int unsigned OSC_FREQ_HZ = 50_000_000;
  localparam int unsigned MPU_DIV = 2;
  localparam int unsigned MPU_FREQ_HZ = OSC_FREQ_HZ / MPU_DIV;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned MPU_PERIOD_NS = NS_PER_S / MPU_FREQ_HZ;
  // ==========================================================
  // local time-out, in processor clocks
  localparam int unsigned TIMEOUT_MPU_CLKS = 524000;
  localparam int unsigned TIMEOUT_W = 20;
  // ==========================================================
  // arbitration, as printed at a 40 ns processor clock
  localparam int unsigned ARB_GRANT_TYP_NS = 120;
  localparam int unsigned ARB_GRANT_MAX_NS = 160;
  localparam int unsigned ARB_GRANT_TICKS = ARB_GRANT_TYP_NS / MPU_PERIOD_NS;
  localparam int unsigned DAISY_TYP_NS = 100;
  localparam int unsigned DAISY_MAX_NS = 140;
  // daisy delay in system clocks, typical time rounded up
  localparam int unsigned DAISY_SYS_CLKS =
    (DAISY_TYP_NS * (OSC_FREQ_HZ / 1_000_000) + 999) / 1000;
  // ==========================================================
  // backplane cycle budget in processor clocks
  localparam int unsigned CYC_SETUP_TICKS = 2;
  localparam int unsigned CYC_READ_TAIL = 3;
  localparam int unsigned CYC_WRITE_TAIL = 4;
  localparam int unsigned CYC_ARB_EXTRA = 3;
  localparam int unsigned CNT_W = 4;
  // ==========================================================
  // error source codes {timeout_source_flag, backplane_error_flag}
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_BACKPLANE = 2'h1,
    SRC_TIMEOUT = 2'h2,
    SRC_DEADLOCK = 2'h3
  } bel_src_t;
endpackage

/* sim/bel_properties.sv */
// concurrent checks on the ports of the bus error and lock block
// assumes binding into bel_top; one clock, reset active high
module bel_properties #(
  parameter int unsigned TIMEOUT_CLKS = 20
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sys_ctrl_in,
  input wire logic interlock_fit_in,
  input wire logic cpu_cyc_in,
  input wire logic cpu_vme_in,
  input wire logic indivisible_cycle_marker_n_in,
  input wire logic slave_req_in,
  input wire logic vme_bbsy_n_in,
  input wire logic vme_br3_n_in,
  input wire logic vme_bg_in_n_in,
  input wire logic vme_berr_n_in,
  input wire logic cpu_berr_n_out,
  input wire logic cpu_halt_n_out,
  input wire logic timeout_source_flag_out,
  input wire logic backplane_error_flag_out,
  input wire logic vme_br_n_out,
  input wire logic vme_bbsy_oe_out,
  input wire logic vme_bg_out_n_out,
  input wire logic vme_ds_n_out
);
  int cnt_q;
  logic dead;
  logic arb;
  logic mk;
  assign mk = indivisible_cycle_marker_n_in;
  assign dead = cpu_cyc_in && cpu_vme_in && slave_req_in;
  assign arb = sys_ctrl_in && vme_br_n_out && vme_bbsy_n_in && !vme_br3_n_in;
  // ==========================================================
  // length of the access still open
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cpu_cyc_in && cpu_berr_n_out) ? cnt_q + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  a_retry_both_low: assert property (
    dead && mk |-> ##[1:4] (!cpu_berr_n_out && !cpu_halt_n_out))
    else $error("retry not raised");
  a_rmw_benign_error: assert property (
    dead && !mk |-> ##[1:4] (!cpu_berr_n_out && cpu_halt_n_out
      && timeout_source_flag_out && backplane_error_flag_out))
    else $error("deadlock error wrong");
  a_halt_with_error: assert property (
    !cpu_halt_n_out |-> !cpu_berr_n_out)
    else $error("halt alone");
  a_backplane_error: assert property (
    !vme_berr_n_in && !vme_ds_n_out && !dead |-> ##[1:4] (!cpu_berr_n_out
      && !timeout_source_flag_out && backplane_error_flag_out))
    else $error("backplane error lost");
  a_flags_hold: assert property (
    $changed({timeout_source_flag_out, backplane_error_flag_out}) |-> !cpu_berr_n_out)
    else $error("flags moved");
  a_timeout_bound: assert property (
    cnt_q <= int'(2 * TIMEOUT_CLKS) + 4)
    else $error("no time-out");
  a_arb_grant_late: assert property (
    arb [*8] |=> !vme_bg_out_n_out)
    else $error("grant late");
  a_grant_pass: assert property (
    !sys_ctrl_in && vme_br_n_out && $fell(vme_bg_in_n_in) |-> ##[4:7] !vme_bg_out_n_out)
    else $error("grant not passed");
  a_no_early_req: assert property (
    (!interlock_fit_in && !cpu_cyc_in) [*4] |-> vme_br_n_out)
    else $error("early request");
  a_lock_hold: assert property (
    interlock_fit_in && !mk && vme_bbsy_oe_out |=> vme_bbsy_oe_out)
    else $error("lock dropped");
endmodule

bind bel_top bel_properties #(.TIMEOUT_CLKS(TIMEOUT_CLKS)) chk_u (.sys_clk_in, .rst_in,
  .sys_ctrl_in, .interlock_fit_in, .cpu_cyc_in, .cpu_vme_in, .indivisible_cycle_marker_n_in,
  .slave_req_in, .vme_bbsy_n_in, .vme_br3_n_in, .vme_bg_in_n_in, .vme_berr_n_in,
  .cpu_berr_n_out, .cpu_halt_n_out, .timeout_source_flag_out, .backplane_error_flag_out,
  .vme_br_n_out, .vme_bbsy_oe_out, .vme_bg_out_n_out, .vme_ds_n_out);

/* sim/bel_top_tb_top.sv */
// self-checking bench for the bus error source and lock block
// assumes the block, its checker and the far side model
module bel_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 40;
  logic clk, rst, sc, ilk, cyc, vme, wr, mk_n, sreq, ob_n, or_n, og, err;
  logic [3:0] dly;
  logic [3:0] ev;
  logic berr_n, halt_n, ack, sgnt, tf, bf, br_n, bbsy_n, oe, bgo_n, ds_n;
  logic dtk_n, verr_n, bgi_n, bbsy_w, br3_w;
  int err_count;
  int checked;
  // ==========================================================
  // shared lines with pull-ups
  assign bbsy_w = (oe ? bbsy_n : 1'b1) & ob_n;
  assign br3_w = br_n & or_n;
  assign ev = {sgnt, ~bgo_n, ~berr_n, ack};
  bel_top #(.TIMEOUT_CLKS(TMO)) dut (.sys_clk_in(clk), .rst_in(rst), .sys_ctrl_in(sc),
    .interlock_fit_in(ilk), .cpu_cyc_in(cyc), .cpu_vme_in(vme), .cpu_write_in(wr),
    .indivisible_cycle_marker_n_in(mk_n), .slave_req_in(sreq), .vme_bbsy_n_in(bbsy_w),
    .vme_br3_n_in(br3_w), .vme_bg_in_n_in(bgi_n), .vme_dtack_n_in(dtk_n),
    .vme_berr_n_in(verr_n), .cpu_berr_n_out(berr_n), .cpu_halt_n_out(halt_n),
    .cpu_ack_out(ack), .slave_grant_out(sgnt), .timeout_source_flag_out(tf),
    .backplane_error_flag_out(bf), .vme_br_n_out(br_n), .vme_bbsy_n_out(bbsy_n),
    .vme_bbsy_oe_out(oe), .vme_bg_out_n_out(bgo_n), .vme_ds_n_out(ds_n));
  bel_vme_model far (.sys_clk_in(clk), .rst_in(rst), .dly_in(dly), .err_in(err),
    .gnt_in(og), .ds_n_in(ds_n), .br_n_in(br_n), .dtack_n_out(dtk_n),
    .berr_n_out(verr_n), .bg_n_out(bgi_n));
  task automatic nclk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi);
    checked++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("BAD %0t count %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask
  // waits for ack, error, grant out or slave grant
  task automatic wt(input int sel, output int n);
    n = 0;
    while (n < 300 && ev[sel] !== 1'b1) begin
      nclk(1);
      n++;
    end
  endtask
  task automatic acc(input logic w, output int n);
    wr = w;
    {cyc, vme} = 2'b11;
    wt(0, n);
    chk({3'h0, ack}, 4'h1);
    {cyc, vme} = 2'b00;
    nclk(3);
  endtask
  task automatic t_cycles();
    int r, w;
    sc = 1;
    acc(1'b0, r);
    acc(1'b1, w);
    chk_rng(w, r + 1, r + 3);
    sc = 0;
    acc(1'b0, r);
    chk_rng(r, 18, 30);
    acc(1'b1, w);
    chk_rng(w, r + 1, r + 3);
    {ilk, mk_n} = 2'b10;
    nclk(12);
    chk({3'h0, oe}, 4'h1);
    acc(1'b0, r);
    chk_rng(r, 9, 17);
    acc(1'b1, w);
    chk_rng(w, r + 1, r + 3);
    dly = 4'h5;
    acc(1'b0, w);
    chk_rng(w, r + 3, r + 5);
    chk({3'h0, oe}, 4'h1);
    {ilk, mk_n, dly} = 6'h11;
    nclk(4);
  endtask
  task automatic t_berr();
    int n;
    {err, cyc, vme, wr} = 4'he;
    wt(1, n);
    chk({berr_n, halt_n, tf, bf}, 4'h5);
    {err, cyc, vme} = 3'h0;
    nclk(3);
    chk({berr_n, halt_n, tf, bf}, 4'hd);
  endtask
  task automatic t_tmo();
    int n;
    cyc = 1;
    wt(1, n);
    chk_rng(n, 2 * TMO - 3, 2 * TMO + 3);
    chk({berr_n, halt_n, tf, bf}, 4'h6);
    cyc = 0;
    nclk(3);
  endtask
  task automatic t_dead();
    int n;
    {sreq, cyc, vme} = 3'h7;
    wt(1, n);
    chk_rng(n, 0, 4);
    chk({berr_n, halt_n, tf, bf}, 4'h2);
    {cyc, vme} = 2'b00;
    wt(3, n);
    chk({3'h0, sgnt}, 4'h1);
    sreq = 0;
    nclk(3);
    mk_n = 0;
    {sreq, cyc, vme} = 3'h7;
    wt(1, n);
    chk({berr_n, halt_n, tf, bf}, 4'h7);
    {sreq, cyc, vme, mk_n} = 4'h1;
    nclk(3);
  endtask
  task automatic t_arb();
    int n;
    og = 1;
    wt(2, n);
    chk_rng(n, 5, 8);
    og = 0;
    nclk(3);
    chk({3'h0, bgo_n}, 4'h1);
    {sc, or_n} = 2'b10;
    wt(2, n);
    chk_rng(n, 5, 9);
    {sc, or_n} = 2'b01;
    nclk(4);
  endtask
  task automatic t_lock();
    mk_n = 0;
    nclk(12);
    chk({3'h0, br_n}, 4'h1);
    mk_n = 1;
    nclk(2);
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (8000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    err_count = 0;
    checked = 0;
    rst = 1;
    {sc, ilk, cyc, vme, wr, sreq, og, err} = 8'h0;
    {mk_n, ob_n, or_n} = 3'h7;
    dly = 4'h1;
    repeat (16) @(posedge clk);
    #2;
    rst = 0;
    nclk(2);
    t_cycles();
    t_berr();
    t_tmo();
    t_dead();
    t_arb();
    t_lock();
    results();
  end
endmodule

/* sim/bel_vme_model.sv */
// far side: backplane slave answering strobes, upstream grant
// assumes released lines read high through pull-ups
module bel_vme_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] dly_in,
  input wire logic err_in,
  input wire logic gnt_in,
  input wire logic ds_n_in,
  input wire logic br_n_in,
  output logic dtack_n_out,
  output logic berr_n_out,
  output logic bg_n_out
);
  logic [3:0] cnt_q;
  // ==========================================================
  // answer after dly_in clocks, release when strobe ends
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 4'h0;
      dtack_n_out <= 1'b1;
      berr_n_out <= 1'b1;
      bg_n_out <= 1'b1;
    end else begin
      bg_n_out <= br_n_in & ~gnt_in;
      if (ds_n_in) begin
        cnt_q <= 4'h0;
        dtack_n_out <= 1'b1;
        berr_n_out <= 1'b1;
      end else if (cnt_q == dly_in) begin
        dtack_n_out <= err_in;
        berr_n_out <= ~err_in;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
